// file: rfc_asserts.sv
// Port assertions for the converter core
`timescale 1ns/100ps
module rfc_asserts (
  input wire        REF_CLK,         // Clock
  input wire        RST_B,           // Reset, active low
  input wire        CLK_EN,          // Clock enable
  input wire [4:0]  AVS_ADDRESS,     // Word address
  input wire        AVS_READ,        // Read strobe
  input wire        AVS_WRITE,       // Write strobe
  input wire [31:0] AVS_WRITEDATA,   // Write data
  input wire [3:0]  AVS_BYTEENABLE,  // Byte enables
  input wire [31:0] AVS_READDATA,    // Read data
  input wire        AVS_WAITREQUEST, // Wait request
  input wire        RETURN_SW_OPEN,  // Switch open
  input wire        THREE_LEAD_EN,   // Lead compensation
  input wire        NOTCH_SELECT,    // Notch select
  input wire        CONV_CONTINUOUS, // Continuous mode
  input wire        CONV_START,      // Start pulse
  input wire        COMPARE_STROBE   // Check pulse
);
  // Accepted configuration write on lane 0
  wire cfg_wr = AVS_WRITE & CLK_EN & (AVS_ADDRESS == 5'h00) &
                AVS_BYTEENABLE[0];
  // Automatic cycle pattern, don't-care bits masked
  wire auto_wr = cfg_wr & ((AVS_WRITEDATA[7:0] & 8'hEC) == 8'h84);
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (!RST_B);
  a_read_stall: assert property ($rose(AVS_READ) && CLK_EN |->
    AVS_WAITREQUEST ##1 !AVS_WAITREQUEST) else $error("read stall bad");
  a_write_nowait: assert property (AVS_WRITE && CLK_EN |->
    !AVS_WAITREQUEST) else $error("write was stalled");
  a_frozen_wait: assert property ((AVS_READ || AVS_WRITE) && !CLK_EN |->
    AVS_WAITREQUEST) else $error("request taken while frozen");
  a_unmapped_ff: assert property (AVS_READ && !AVS_WAITREQUEST &&
    AVS_ADDRESS[4:3] != 2'h0 |-> AVS_READDATA == 32'h000000FF)
    else $error("unmapped read not FF");
  a_notch_follow: assert property (cfg_wr |->
    ##2 NOTCH_SELECT == $past(AVS_WRITEDATA[0], 2))
    else $error("notch output wrong");
  a_three_lead: assert property (cfg_wr && !AVS_WRITEDATA[5] |->
    ##2 THREE_LEAD_EN == $past(AVS_WRITEDATA[4], 2))
    else $error("three lead output wrong");
  a_start_pulse: assert property (CONV_START |=> !CONV_START)
    else $error("start pulse too long");
  a_busy_nostart: assert property (RETURN_SW_OPEN |->
    !CONV_START && !CONV_CONTINUOUS) else $error("conversion in cycle");
  a_auto_settle: assert property (auto_wr |=>
    !COMPARE_STROBE [*8]) else $error("check before settling");
  // Main scenarios reached
  c_auto: cover property (auto_wr);
  c_open: cover property ($rose(RETURN_SW_OPEN));
  c_start: cover property (CONV_START);
endmodule // rfc_asserts

bind rfc_core rfc_asserts i_rfc_asserts (.*);

// file: rfc_consts.vh
// Constants for the sensor converter configuration and fault cycle block
`ifndef RFC_CONSTS_VH
`define RFC_CONSTS_VH

// Register indices (byte address is four times the index)
`define RFC_IDX_CFG        3'h0
`define RFC_IDX_RES_HIGH   3'h1
`define RFC_IDX_RES_LOW    3'h2
`define RFC_IDX_FLT_STAT   3'h7
`define RFC_IDX_ANALOG     3'h3
`define RFC_IDX_IDLE_W     3'h4

// Configuration register fields
`define RFC_CFG_BIAS       7
`define RFC_CFG_CONT       6
`define RFC_CFG_SINGLE     5
`define RFC_CFG_THREE_LEAD 4
`define RFC_CFG_CYC_HI     3
`define RFC_CFG_CYC_LO     2
`define RFC_CFG_CLEAR      1
`define RFC_CFG_NOTCH      0
`define RFC_CFG_RESET      8'h00

// Cycle control field codes
`define RFC_CYC_DONE       2'h0
`define RFC_CYC_AUTO       2'h1
`define RFC_CYC_MAN1       2'h2
`define RFC_CYC_MAN2       2'h3

// Fault status bit positions
`define RFC_FLT_HIGH       7
`define RFC_FLT_LOW        6
`define RFC_FLT_REF_HI     5
`define RFC_FLT_REF_LO     4
`define RFC_FLT_SNS_LO     3
`define RFC_FLT_OVUV       2

// Pattern masks: bit 7 set, bits 6 and 5 clear
`define RFC_FDC_MASK       8'hE0
`define RFC_FDC_MATCH      8'h80

// Settling time before an automatic check, in ns, and clock period in ns
`define RFC_SETTLE_NS      100000
`define RFC_CLK_NS         5

// Threshold register reset values and read data fill words
`define RFC_THR_HIGH_RST   15'h7FFF
`define RFC_THR_LOW_RST    15'h0000
`define RFC_DATA_ZERO      32'h00000000
`define RFC_DATA_ONES      8'hFF

`endif

// file: rfc_core.v
// Configuration, fault cycle sequencer and result registers of the converter
//
// Behaviour
// - Three-lead bit selects lead drop compensation
// - Three comparisons set fault bits 5,4,3
// - Automatic cycle pattern forces idle conversion mode
// - Wait settling time before each automatic check
// - Automatic cycle completion clears cycle field
// - Manual step one checks closed, then opens
// - Manual step two checks open, closes, clears
// - Single-shot with cycle bits ignores both
// - Step two without step one runs automatic
// - Clear bit with zero D5/D3/D2 clears faults
// - Persisting overvoltage sets flag again immediately
// - Clear bit reads back as zero
// - Notch bit selects 60Hz or 50Hz rejection
// - Cycle field reports sequencer progress
// - Result is 15-bit ratio, MSB-aligned
// - Result low bit zero is fault summary
// - Mode bit selects continuous or idle
// - Single-shot starts one conversion, self-clears
// - Bias bit drives bias output, forced continuous
// - Fault status latches until cleared
//
// The Avalon-MM register port is this design's own decision.
`timescale 1ns/100ps
`include "rfc_consts.vh"

module rfc_core #(
  parameter SETTLE_CYC = `RFC_SETTLE_NS / `RFC_CLK_NS, // Settling cycles
  parameter DATA_W     = 15                            // Result width
) (
  input  wire        REF_CLK,        // System clock, 200 MHz
  input  wire        RST_B,          // Asynchronous reset, active low
  input  wire        CLK_EN,         // Clock enable, freezes state when low
  input  wire [4:0]  AVS_ADDRESS,    // Avalon word address
  input  wire        AVS_READ,       // Avalon read strobe
  input  wire        AVS_WRITE,      // Avalon write strobe
  input  wire [31:0] AVS_WRITEDATA,  // Avalon write data
  input  wire [3:0]  AVS_BYTEENABLE, // Avalon byte enables
  output reg  [31:0] AVS_READDATA,   // Avalon read data
  output wire        AVS_WAITREQUEST,// Avalon wait request
  input  wire        LINK_CS_B,      // Link chip select pin, active low
  input  wire        CONV_DONE,      // Converter result ready pulse
  input  wire [14:0] CONV_DATA,      // Converter ratio result
  input  wire        CMP_REF_HIGH,   // Reference-low above threshold
  input  wire        CMP_REF_LOW,    // Reference-low below threshold
  input  wire        CMP_SNS_LOW,    // Sense-low below threshold
  input  wire        OVUV_PIN,       // Over/undervoltage detector level
  output reg         BIAS_VOLTAGE_OUTPUT, // Bias voltage enable
  output reg         RETURN_SW_OPEN, // Return-path switch open
  output reg         THREE_LEAD_EN,  // Lead drop compensation enable
  output reg         NOTCH_SELECT,   // 1 = 50Hz notch, 0 = 60Hz notch
  output reg         CONV_CONTINUOUS,// Converter runs continuously
  output reg         CONV_START,     // Single conversion start pulse
  output reg         COMPARE_STROBE  // Comparators sampled the cycle before
);

  // Sequencer states, one-hot.
  // Automatic run: AWAIT and ACHK alternate three times, each check only
  // after a full settling wait, then back to IDLE with the field cleared.
  // Manual run: M1 checks with the switch closed and opens it, MHOLD
  // parks until the host writes step two, M2 checks open and closes.
  // One-hot keeps every state test a single flip-flop, at the cost of
  // six registers where three would do.
  // Any code outside the six falls back to IDLE through the default arm.
  localparam [5:0] S_IDLE  = 6'h01; // No cycle
  localparam [5:0] S_AWAIT = 6'h02; // Automatic settling wait
  localparam [5:0] S_ACHK  = 6'h04; // Automatic check
  localparam [5:0] S_M1    = 6'h08; // Manual step one check
  localparam [5:0] S_MHOLD = 6'h10; // Waiting for step two write
  localparam [5:0] S_M2    = 6'h20; // Manual step two check

  // Register file and sequencer bookkeeping.
  // The thresholds are fixed at their power-on values in this block; the
  // comparison hardware is kept so a later register port can load them.
  reg  [7:0]  cfg;          // Configuration register
  reg  [7:0]  fault;        // Fault status
  reg  [14:0] result;       // Conversion result
  reg  [14:0] thr_high;     // High threshold
  reg  [14:0] thr_low;      // Low threshold
  reg  [5:0]  state;        // Sequencer state
  reg  [5:0]  next_state;   // Next sequencer state
  reg  [16:0] settle_cnt;   // Settling counter
  reg  [1:0]  auto_phase;   // Automatic check index
  reg         single_pend;  // Single shot awaits chip select rise
  reg  [1:0]  cs_sync;      // Chip select synchroniser
  reg         cs_prev;      // Last synchronised chip select
  reg  [1:0]  ovuv_sync;    // Overvoltage synchroniser
  reg         rd_ack;       // Read answer phase

  // Decode of a word index from the bus address
  // Only the low three address bits pick a register; the upper two bits
  // are tested separately so a stray high address reads as unmapped.
  function [2:0] idx_of;
    input [4:0] a;
    begin
      idx_of = a[2:0];
    end
  endfunction

  // Fault cycle pattern with a given cycle code
  // Bit 7 set and bits 6 and 5 clear are the fixed part of every cycle
  // pattern; bits 4, 1 and 0 are free and ride along with the write.
  // A set single-shot bit therefore never matches, which keeps the
  // conflict case out of the sequencer even ahead of its own conflict test.
  function is_fdc;
    input [7:0] d;
    input [1:0] code;
    begin
      is_fdc = ((d & `RFC_FDC_MASK) == `RFC_FDC_MATCH) &&
               (d[`RFC_CFG_CYC_HI:`RFC_CFG_CYC_LO] == code);
    end
  endfunction

  wire [2:0] idx     = idx_of(AVS_ADDRESS);         // Register index
  wire       mapped  = (AVS_ADDRESS[4:3] == 2'h0);  // Upper range unmapped
  wire       wr_cfg  = AVS_WRITE && CLK_EN && mapped &&
                       AVS_BYTEENABLE[0] && (idx == `RFC_IDX_CFG);
  wire [7:0] wd      = AVS_WRITEDATA[7:0];          // Written byte
  wire       wd_cyc  = wd[`RFC_CFG_CYC_HI] | wd[`RFC_CFG_CYC_LO];
  wire       conflict = wd[`RFC_CFG_SINGLE] & wd_cyc;
  wire       busy    = (state != S_IDLE);           // Cycle in progress
  wire       cs_rise = cs_sync[1] & ~cs_prev;       // End of link transaction
  wire       ovuv    = ovuv_sync[1];                // Synchronised level

  // Writes finish at once, reads take one extra cycle for registered data.
  // While the clock enable is low nothing can be taken, so every request
  // is stalled; otherwise a write would look accepted and be dropped.
  assign AVS_WAITREQUEST = (AVS_READ & ~rd_ack) |
                           ((AVS_READ | AVS_WRITE) & ~CLK_EN);

  // Pin synchronisers, first stage read only by the second
  // Chip select resets high, its idle level, so the edge detector cannot
  // report a false rising edge when reset is released.
  // The voltage detector is a level from the analog side with no relation
  // to this clock, hence the same two-stage treatment.
  always @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      cs_sync   <= 2'h3;
      ovuv_sync <= 2'h0;
      cs_prev   <= 1'b1;
    end else if (CLK_EN) begin
      cs_sync   <= {cs_sync[0], LINK_CS_B};
      ovuv_sync <= {ovuv_sync[0], OVUV_PIN};
      cs_prev   <= cs_sync[1];
    end
  end

  // Sequencer next state
  // Requests are only taken in IDLE, or step two in MHOLD; anything the
  // host writes while a check is pending is stored but does not restart
  // the sequencer, so a busy field can never be overwritten mid-cycle.
  // A step two pattern seen in IDLE falls through to the automatic run.
  always @* begin
    next_state = state;
    case (state)
      S_IDLE: begin
        if (wr_cfg && !conflict) begin
          if (is_fdc(wd, `RFC_CYC_AUTO) || is_fdc(wd, `RFC_CYC_MAN2))
            next_state = S_AWAIT;
          else if (is_fdc(wd, `RFC_CYC_MAN1))
            next_state = S_M1;
        end
      end
      S_AWAIT: begin
        if (settle_cnt == 17'h00000)
          next_state = S_ACHK;
      end
      S_ACHK: begin
        if (auto_phase == 2'h2)
          next_state = S_IDLE;
        else
          next_state = S_AWAIT;
      end
      S_M1: next_state = S_MHOLD;
      S_MHOLD: begin
        if (wr_cfg && !conflict && is_fdc(wd, `RFC_CYC_MAN2))
          next_state = S_M2;
      end
      S_M2: next_state = S_IDLE;
      default: next_state = S_IDLE;
    endcase
  end

  // Sequencer registers, switch and settling count
  // The settling counter loads one less than the wait so that the check
  // state starts exactly a full settling time after the request edge.
  // The compare strobe trails each check state by one cycle; it is meant
  // for the analog side to see which sample the flags came from.
  always @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      state          <= S_IDLE;
      settle_cnt     <= 17'h00000;
      auto_phase     <= 2'h0;
      RETURN_SW_OPEN <= 1'b0;
      COMPARE_STROBE <= 1'b0;
    end else if (CLK_EN) begin
      state          <= next_state;
      COMPARE_STROBE <= (state == S_ACHK) || (state == S_M1) ||
                        (state == S_M2);
      if (next_state == S_AWAIT)
        settle_cnt <= (state == S_AWAIT) ? settle_cnt - 17'h00001
                                         : SETTLE_CYC[16:0] - 17'h00001;
      if (state == S_IDLE)
        auto_phase <= 2'h0;
      else if (state == S_ACHK)
        auto_phase <= auto_phase + 2'h1;
      // Automatic checks 2 and 3 run with the return switch open
      if (state == S_ACHK)
        RETURN_SW_OPEN <= (auto_phase != 2'h2);
      else if (state == S_M1)
        RETURN_SW_OPEN <= 1'b1;
      else if (state == S_M2)
        RETURN_SW_OPEN <= 1'b0;
    end
  end

  // Fault comparison for the active check
  wire chk_closed = (state == S_M1) ||
                    (state == S_ACHK && auto_phase == 2'h0);
  wire chk_open   = (state == S_M2) ||
                    (state == S_ACHK && auto_phase != 2'h0);
  wire clr_req    = wr_cfg && wd[`RFC_CFG_CLEAR] && !wd[`RFC_CFG_SINGLE] &&
                    !wd_cyc;

  // Configuration register with self-clearing bits
  // Single-shot and clear never stay set: they are acted on and stored
  // as zero, so a read never shows a request still pending.
  always @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      cfg         <= `RFC_CFG_RESET;
      single_pend <= 1'b0;
      CONV_START  <= 1'b0;
    end else if (CLK_EN) begin
      CONV_START <= 1'b0;
      if (wr_cfg) begin
        cfg <= {wd[7:6], 1'b0, wd[4], 2'h0, 1'b0, wd[0]};
        if (!conflict && !busy && wd[`RFC_CFG_SINGLE] &&
            !wd[`RFC_CFG_CONT])
          single_pend <= 1'b1;
        if (!conflict && !busy && wd_cyc) begin
          cfg[`RFC_CFG_CONT] <= 1'b0;
          if (is_fdc(wd, `RFC_CYC_MAN1))
            cfg[3:2] <= `RFC_CYC_MAN1;
          else if (is_fdc(wd, `RFC_CYC_AUTO) || is_fdc(wd, `RFC_CYC_MAN2))
            cfg[3:2] <= `RFC_CYC_AUTO;
        end else if (state == S_MHOLD && !conflict &&
                     is_fdc(wd, `RFC_CYC_MAN2)) begin
          cfg[`RFC_CFG_CONT] <= 1'b0;
          cfg[3:2] <= `RFC_CYC_MAN2;
        end else if (busy)
          cfg[3:2] <= cfg[3:2];
      end
      // Completion comes last so that a write landing in the final check
      // cycle cannot leave a stale code behind once the sequencer is idle
      if ((state == S_ACHK && next_state == S_IDLE) || state == S_M2)
        cfg[3:2] <= `RFC_CYC_DONE;
      if (single_pend && cs_rise && !busy) begin
        single_pend <= 1'b0;
        CONV_START  <= 1'b1;
      end
    end
  end

  // Outputs steered by the configuration
  // All steering outputs lag the register by one cycle, which keeps them
  // glitch free at the analog switches.
  always @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      BIAS_VOLTAGE_OUTPUT <= 1'b0;
      THREE_LEAD_EN       <= 1'b0;
      NOTCH_SELECT        <= 1'b0;
      CONV_CONTINUOUS     <= 1'b0;
    end else if (CLK_EN) begin
      BIAS_VOLTAGE_OUTPUT <= cfg[`RFC_CFG_BIAS] | cfg[`RFC_CFG_CONT];
      THREE_LEAD_EN       <= cfg[`RFC_CFG_THREE_LEAD];
      NOTCH_SELECT        <= cfg[`RFC_CFG_NOTCH];
      CONV_CONTINUOUS     <= cfg[`RFC_CFG_CONT] & ~busy;
    end
  end

  // Fault latches and result; a held overvoltage wins over a clear
  // Each flag is set in the same process as the clear and after it, so
  // an event in the clearing cycle is kept rather than lost.
  // Result updates pause while the voltage detector is active; the last
  // good ratio stays readable until the fault goes away.
  always @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      fault    <= 8'h00;
      result   <= 15'h0000;
      thr_high <= `RFC_THR_HIGH_RST;
      thr_low  <= `RFC_THR_LOW_RST;
    end else if (CLK_EN) begin
      if (clr_req)
        fault <= 8'h00;
      if (chk_closed && CMP_REF_HIGH)
        fault[`RFC_FLT_REF_HI] <= 1'b1;
      if (chk_open && CMP_REF_LOW)
        fault[`RFC_FLT_REF_LO] <= 1'b1;
      if (chk_open && CMP_SNS_LOW)
        fault[`RFC_FLT_SNS_LO] <= 1'b1;
      if (ovuv)
        fault[`RFC_FLT_OVUV] <= 1'b1;
      // Updates halt while a voltage fault is present
      if (CONV_DONE && !ovuv) begin
        result <= CONV_DATA;
        if (CONV_DATA >= thr_high)
          fault[`RFC_FLT_HIGH] <= 1'b1;
        if (CONV_DATA <= thr_low)
          fault[`RFC_FLT_LOW] <= 1'b1;
      end
    end
  end

  // Registered read data, one wait cycle per read
  // Registering the read word costs one wait state per read but keeps
  // the bus data off the long decode path.
  // Upper lanes always read zero; unmapped words read FF in lane 0.
  always @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      rd_ack       <= 1'b0;
      AVS_READDATA <= `RFC_DATA_ZERO;
    end else if (CLK_EN) begin
      rd_ack <= AVS_READ & ~rd_ack;
      if (AVS_READ && !rd_ack) begin
        AVS_READDATA <= `RFC_DATA_ZERO;
        if (!mapped)
          AVS_READDATA[7:0] <= `RFC_DATA_ONES;
        else
          case (idx)
            `RFC_IDX_CFG:      AVS_READDATA[7:0] <= cfg;
            `RFC_IDX_RES_HIGH: AVS_READDATA[7:0] <= result[14:7];
            `RFC_IDX_RES_LOW:
              AVS_READDATA[7:0] <= {result[6:0], |fault[7:2]};
            `RFC_IDX_FLT_STAT: AVS_READDATA[7:0] <= {fault[7:2], 2'h0};
            default:           AVS_READDATA[7:0] <= `RFC_DATA_ONES;
          endcase
      end
    end
  end

endmodule // rfc_core

// file: rfc_front.sv
// Analog front end model: converter and fault comparators
`timescale 1ns/100ps
module rfc_front (
  input  wire        clk,          // Core clock
  input  wire        conv_start,   // Start pulse from core
  input  wire        sw_open,      // Return switch open
  input  wire [14:0] ratio,        // Ratio to report
  input  wire        ref_hi_flt,   // Reference lead fault
  input  wire        open_flt,     // Open element fault
  output reg         conv_done,    // Result strobe
  output reg  [14:0] conv_data,    // Result value
  output wire        cmp_ref_high, // Reference-low above threshold
  output wire        cmp_ref_low,  // Reference-low below, switch open
  output wire        cmp_sns_low   // Sense-low below, switch open
);
  reg [3:0] cnt;  // Conversion time left
  reg       busy; // Conversion running
  initial begin
    conv_done = 1'b0;
    conv_data = 15'h0000;
    busy      = 1'b0;
    cnt       = 4'h0;
  end
  // Open faults only show with the switch open
  assign cmp_ref_high = ref_hi_flt;
  assign cmp_ref_low  = sw_open & open_flt;
  assign cmp_sns_low  = sw_open & open_flt;
  // Data churns outside the strobe so stale values never look valid
  always @(posedge clk) begin
    conv_done <= 1'b0;
    conv_data <= ~conv_data;
    if (conv_start) begin
      busy <= 1'b1;
      cnt  <= 4'hF;
    end else if (busy) begin
      cnt <= cnt - 4'h1;
      if (cnt == 4'h0) begin
        busy      <= 1'b0;
        conv_done <= 1'b1;
        conv_data <= ratio;
      end
    end
  end
endmodule // rfc_front

// file: testbench.sv
// Self-checking bench for the converter core
`timescale 1ns/100ps
`include "rfc_consts.vh"
module testbench;
  reg         REF_CLK, RST_B, AVS_READ, AVS_WRITE, LINK_CS_B, OVUV_PIN;
  reg  [4:0]  AVS_ADDRESS;    // Word address
  reg  [31:0] AVS_WRITEDATA;  // Write data
  reg  [3:0]  AVS_BYTEENABLE; // Byte enables
  wire [31:0] AVS_READDATA;   // Read data
  wire        AVS_WAITREQUEST, CONV_DONE, CMP_REF_HIGH, CMP_REF_LOW;
  wire        CMP_SNS_LOW, BIAS_VOLTAGE_OUTPUT, RETURN_SW_OPEN;
  wire        THREE_LEAD_EN, NOTCH_SELECT, CONV_CONTINUOUS, CONV_START;
  wire        COMPARE_STROBE;
  wire [14:0] CONV_DATA;      // Converter result
  reg         CLK_EN;         // Clock enable, dropped by the freeze test
  reg         ref_hi_flt, open_flt;
  reg  [14:0] ratio;          // Ratio the front end returns
  reg  [7:0]  v;              // Last read byte
  integer     err_count, comparisons, n, starts, strobes, s0;
  rfc_core #(.SETTLE_CYC(20)) i_rfc_core (
    .REF_CLK(REF_CLK), .RST_B(RST_B), .CLK_EN(CLK_EN),
    .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ),
    .AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA),
    .AVS_BYTEENABLE(AVS_BYTEENABLE), .AVS_READDATA(AVS_READDATA),
    .AVS_WAITREQUEST(AVS_WAITREQUEST), .LINK_CS_B(LINK_CS_B),
    .CONV_DONE(CONV_DONE), .CONV_DATA(CONV_DATA),
    .CMP_REF_HIGH(CMP_REF_HIGH), .CMP_REF_LOW(CMP_REF_LOW),
    .CMP_SNS_LOW(CMP_SNS_LOW), .OVUV_PIN(OVUV_PIN),
    .BIAS_VOLTAGE_OUTPUT(BIAS_VOLTAGE_OUTPUT),
    .RETURN_SW_OPEN(RETURN_SW_OPEN), .THREE_LEAD_EN(THREE_LEAD_EN),
    .NOTCH_SELECT(NOTCH_SELECT), .CONV_CONTINUOUS(CONV_CONTINUOUS),
    .CONV_START(CONV_START), .COMPARE_STROBE(COMPARE_STROBE));
  rfc_front i_rfc_front (.clk(REF_CLK), .conv_start(CONV_START),
    .sw_open(RETURN_SW_OPEN), .ratio(ratio), .ref_hi_flt(ref_hi_flt),
    .open_flt(open_flt), .conv_done(CONV_DONE), .conv_data(CONV_DATA),
    .cmp_ref_high(CMP_REF_HIGH), .cmp_ref_low(CMP_REF_LOW),
    .cmp_sns_low(CMP_SNS_LOW));
  initial begin
    REF_CLK = 1'b0;
    forever #2.5 REF_CLK = ~REF_CLK;
  end
  // Pulse counters; tasks read them a cycle or more after the pulse
  always @(posedge REF_CLK) begin
    if (CONV_START === 1'b1) starts <= starts + 1;
    if (COMPARE_STROBE === 1'b1) strobes <= strobes + 1;
  end
  // Stimulus moves by non-blocking assignment right after this edge, and
  // handshake outputs read here still hold their pre-edge values
  task tick; begin @(posedge REF_CLK); end endtask
  task chk(input [8*10-1:0] nm, input [31:0] got, input [31:0] exp);
    begin
      comparisons = comparisons + 1;
      if (got !== exp) begin
        err_count = err_count + 1;
        $display("BAD %0s exp %h seen %h", nm, exp, got);
      end
    end
  endtask
  // Bus write; held until waitrequest seen low
  task wr(input [4:0] a, input [7:0] d, input [3:0] be);
    begin
      AVS_ADDRESS <= a;
      AVS_WRITEDATA <= {24'h000000, d};
      AVS_BYTEENABLE <= be;
      AVS_WRITE <= 1'b1;
      tick;
      while (AVS_WAITREQUEST !== 1'b0) tick;
      AVS_WRITE <= 1'b0;
      tick;
    end
  endtask
  // Bus read; data taken at the answer edge
  task rd(input [4:0] a);
    begin
      AVS_ADDRESS <= a;
      AVS_READ <= 1'b1;
      tick;
      while (AVS_WAITREQUEST !== 1'b0) tick;
      v = AVS_READDATA[7:0];
      AVS_READ <= 1'b0;
      tick;
    end
  endtask
  task chk_rd(input [8*10-1:0] nm, input [4:0] a, input [7:0] e);
    begin rd(a); chk(nm, {24'h000000, v}, {24'h000000, e}); end
  endtask
  // Chip select frame, 160 ns link period
  task cs_pulse; begin
    LINK_CS_B <= 1'b0; repeat (16) tick;
    LINK_CS_B <= 1'b1; repeat (16) tick;
  end endtask
  // Poll cycle field until finished
  task wait_done; begin
    v = 8'h0C;
    repeat (100) if (v[3:2] !== 2'h0) rd(5'h00);
    chk("cyc_done", {24'h000000, v}, 32'h00000080);
  end endtask
  task t_reset; begin
    chk_rd("cfg_rst", 5'h00, 8'h00);
    chk_rd("res_hi", 5'h01, 8'h00);
    chk_rd("res_lo", 5'h02, 8'h00);
    chk_rd("fault", 5'h07, 8'h00);
    chk_rd("thr", 5'h03, 8'hFF);
    chk_rd("unmapped", 5'h08, 8'hFF);
    wr(5'h01, 8'h55, 4'hF);
    chk_rd("ro_write", 5'h01, 8'h00);
  end endtask
  task t_cfg; begin
    wr(5'h00, 8'hD1, 4'hF);
    chk_rd("cfg_rb", 5'h00, 8'hD1);
    chk("outs", {28'h0, BIAS_VOLTAGE_OUTPUT, CONV_CONTINUOUS,
      THREE_LEAD_EN, NOTCH_SELECT}, 32'hF);
    wr(5'h00, 8'h22, 4'hE);
    chk_rd("be_off", 5'h00, 8'hD1);
    wr(5'h00, 8'h41, 4'hF);
    repeat (2) tick;
    chk("bias_cont", {30'h0, BIAS_VOLTAGE_OUTPUT, NOTCH_SELECT}, 3);
    wr(5'h00, 8'h01, 4'hF);
    repeat (2) tick;
    chk("bias_off", {30'h0, BIAS_VOLTAGE_OUTPUT, CONV_CONTINUOUS},
      0);
  end endtask
  // Frozen clock enable: requests stall, pins are not sampled
  task t_freeze; begin
    CLK_EN <= 1'b0;
    OVUV_PIN <= 1'b1;
    fork
      wr(5'h00, 8'h80, 4'hF);
      begin
        repeat (6) tick;
        chk("frozen", {31'h0, NOTCH_SELECT}, 1);
        OVUV_PIN <= 1'b0;
        CLK_EN <= 1'b1;
      end
    join
    chk_rd("thaw_flt", 5'h07, 8'h00);
    chk_rd("thaw_cfg", 5'h00, 8'h80);
    chk("thaw_notch", {31'h0, NOTCH_SELECT}, 0);
  end endtask
  task t_single; begin
    ratio <= 15'h0333;
    wr(5'h00, 8'hA0, 4'hF);
    n = starts;
    repeat (8) tick;
    chk("early", starts - n, 0);
    cs_pulse;
    chk("one_start", starts - n, 1);
    repeat (20) tick;
    chk_rd("res_hi", 5'h01, 8'h06);
    chk_rd("res_lo", 5'h02, 8'h66);
    chk_rd("cfg_d5", 5'h00, 8'h80);
  end endtask
  task t_auto; begin
    ref_hi_flt <= 1'b1;
    s0 = strobes;
    wr(5'h00, 8'h84, 4'hF);
    chk_rd("cyc_auto", 5'h00, 8'h84);
    chk("idle", {31'h0, CONV_CONTINUOUS}, 0);
    wait_done;
    chk_rd("flt_ref", 5'h07, 8'h20);
    chk("auto_chks", strobes - s0, 3);
    chk_rd("summary", 5'h02, 8'h67);
    ref_hi_flt <= 1'b0;
  end endtask
  task t_clear; begin
    OVUV_PIN <= 1'b1;
    repeat (4) tick;
    wr(5'h00, 8'h82, 4'hF);
    chk_rd("ovuv", 5'h07, 8'h04);
    chk_rd("ov_lo", 5'h02, 8'h67);
    chk_rd("cfg_d1", 5'h00, 8'h80);
    OVUV_PIN <= 1'b0;
    repeat (4) tick;
    chk_rd("latch", 5'h07, 8'h04);
    wr(5'h00, 8'h82, 4'hF);
    chk_rd("cleared", 5'h07, 8'h00);
    chk_rd("lo_clear", 5'h02, 8'h66);
  end endtask
  task t_manual; begin
    open_flt <= 1'b1;
    s0 = strobes;
    repeat (40) tick;
    wr(5'h00, 8'h88, 4'hF);
    repeat (40) tick;
    chk("sw_open", {31'h0, RETURN_SW_OPEN}, 1);
    chk_rd("man_hold", 5'h00, 8'h88);
    wr(5'h00, 8'h8C, 4'hF);
    wait_done;
    chk("sw_closed", {31'h0, RETURN_SW_OPEN}, 0);
    chk_rd("flt_open", 5'h07, 8'h18);
    chk("man_chks", strobes - s0, 2);
    open_flt <= 1'b0;
    wr(5'h00, 8'h82, 4'hF);
  end endtask
  task t_step2; begin
    wr(5'h00, 8'h8C, 4'hF);
    chk_rd("to_auto", 5'h00, 8'h84);
    wait_done;
  end endtask
  task t_conflict; begin
    ref_hi_flt <= 1'b1;
    n = starts;
    wr(5'h00, 8'hA4, 4'hF);
    chk_rd("both_off", 5'h00, 8'h80);
    cs_pulse;
    repeat (80) tick;
    chk("no_start", starts - n, 0);
    chk_rd("no_check", 5'h07, 8'h00);
  end endtask
  task finish_test; begin
    $display("comparisons %0d err_count %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  end endtask
  initial begin
    {RST_B, AVS_READ, AVS_WRITE, OVUV_PIN, ref_hi_flt, open_flt} = 6'h00;
    {LINK_CS_B, AVS_ADDRESS, AVS_WRITEDATA} = 38'h1_00000000 << 5;
    AVS_BYTEENABLE = 4'h0;
    CLK_EN = 1'b1;
    strobes = 0;
    ratio = 15'h0000;
    {err_count, comparisons, starts} = {32'd0, 32'd0, 32'd0};
    repeat (20) @(posedge REF_CLK);
    RST_B <= 1'b1;
    tick;
    t_reset; t_cfg; t_freeze; t_single; t_auto; t_clear;
    t_manual; t_step2; t_conflict;
    finish_test;
  end
  // Watchdog well past the expected run length
  initial begin
    #100000;
    err_count = err_count + 1;
    finish_test;
  end
endmodule // testbench
